// ==== rtl/spfg_cfg.svh ====
// constants for the self-program flash guard
`ifndef SPFG_CFG_SVH
`define SPFG_CFG_SVH
`define SPFG_ADDR_W       13
`define SPFG_NO_READ_WHILE_WRITE_REGION_START   13'h1c00
`define SPFG_BOOT_W_4     13'h1f80
`define SPFG_BOOT_W_3     13'h1f00
`define SPFG_BOOT_W_2     13'h1e00
`define SPFG_BOOT_W_1     13'h1c00
`define SPFG_LOCK_RST     4'h3
`endif

// ==== rtl/spfg_guard.sv ====
// access guard and read-while-write control for self-programmed flash
`timescale 1ns/10ps
`include "spfg_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - stores from application part are ignored
// - boot-part stores may target any address
// - classify address as rww or no_read_while_write_region region
// - rww programming keeps cpu running, no_read_while_write_region readable
// - no_read_while_write_region programming stalls cpu, no reads
// - busy flag high while rww region blocked
// - boot part always inside no_read_while_write_region region
// - lock bits set back to 1 only by chip erase, or by reset to 4'h3
// - general write lock ignored for stores
// - general read/write lock ignored for loads
// - both lock bits high means no restriction
// - app write lock blocks stores into app
// - app read lock blocks boot loads of app
// - app read lock masks irq in app when vectors in boot
// - boot write lock blocks stores into boot
// - boot read lock blocks app loads of boot
// - boot read lock masks irq in boot when vectors in app
// - rww page operation sets busy flag
// - reenable or page load clears busy
module spfg_guard
    import spfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire spfg_req_t   req,
    input  wire logic        op_done,
    input  wire logic [1:0]  boot_size_fuses,
    input  wire logic        chip_erase,
    input  wire logic        ivec_in_boot,
    input  wire logic        gen_lock_w,
    input  wire logic        gen_lock_rw,
    output logic             store_grant,
    output logic             load_grant,
    output logic             cpu_stall,
    output logic             rww_busy_flag,
    output logic             irq_mask,
    output logic [3:0]       lock_bits
);

    ////////////////////////////////////////////////////////////////////////
    // decode of regions
    spfg_addr_t  boot_start;
    logic        tgt_boot;
    logic        exe_boot;
    logic        tgt_rww;
    logic        exe_rww;
    logic        app_wl;
    logic        app_rl;
    logic        boot_wl;
    logic        boot_rl;
    logic        st_ok;
    logic        ld_ok;
    logic        start_op;
    logic        rww_read;
    logic        lock_wr;
    logic        gen_unused;
    spfg_state_t state_q;
    spfg_state_t state_d;
    logic [3:0]  lock_q;
    logic        busy_q;
    logic        busy_d;

    // every boot size ends at the top and starts at or above the no_read_while_write_region start: rule holds
    assign boot_start = (boot_size_fuses == 2'h3) ? `SPFG_BOOT_W_4 :
                        (boot_size_fuses == 2'h2) ? `SPFG_BOOT_W_3 :
                        (boot_size_fuses == 2'h1) ? `SPFG_BOOT_W_2 :
                                                    `SPFG_BOOT_W_1;
    assign tgt_boot = (req.target >= boot_start);
    assign exe_boot = (req.exec >= boot_start);
    assign tgt_rww  = (req.target < `SPFG_NO_READ_WHILE_WRITE_REGION_START);
    assign exe_rww  = (req.exec < `SPFG_NO_READ_WHILE_WRITE_REGION_START);
    // lock bit order: {boot_read, boot_write, app_read, app_write}
    assign app_wl  = ~lock_q[0];
    assign app_rl  = ~lock_q[1];
    assign boot_wl = ~lock_q[2];
    assign boot_rl = ~lock_q[3];
    // general lock inputs are deliberately not looked at
    assign gen_unused = gen_lock_w | gen_lock_rw;

    ////////////////////////////////////////////////////////////////////////
    // access checks
    assign st_ok = req.store & exe_boot & (state_q == SPFG_IDLE) &
                   ~(tgt_boot ? boot_wl : app_wl);
    // a load reads rww while busy is an illegal read and is refused
    assign rww_read = tgt_rww & busy_q;
    assign ld_ok = req.load & (state_q != SPFG_NO_READ_WHILE_WRITE_REGION_BUSY) & ~rww_read &
                   ~(exe_boot & ~tgt_boot & app_rl) &
                   ~(~exe_boot & tgt_boot & boot_rl);
    assign start_op = st_ok & req.page_op;
    assign lock_wr  = st_ok & req.lock_set;

    ////////////////////////////////////////////////////////////////////////
    // programming state machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SPFG_IDLE:
            begin
                if (start_op)
                    state_d = tgt_rww ? SPFG_RWW_BUSY
                                      : SPFG_NO_READ_WHILE_WRITE_REGION_BUSY;
            end
            SPFG_RWW_BUSY:  if (op_done) state_d = SPFG_IDLE;
            SPFG_NO_READ_WHILE_WRITE_REGION_BUSY: if (op_done) state_d = SPFG_IDLE;
            default:        state_d = SPFG_IDLE;
        endcase
    end

    // busy: a new rww start wins over a clear in the same cycle
    assign busy_d = (start_op & tgt_rww) ? 1'b1 :
                    ((st_ok & req.page_load) |
                     (st_ok & req.reenable & (state_q == SPFG_IDLE)))
                        ? 1'b0 : busy_q;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= SPFG_IDLE;
            busy_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            busy_q  <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock bits: software may only program (clear) bits, erase restores
    always_ff @(posedge clk)
    begin
        if (!rstn)
            lock_q <= `SPFG_LOCK_RST;
        else if (chip_erase)
            lock_q <= 4'hf;
        else if (lock_wr)
            lock_q <= lock_q & req.lock_data;
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            store_grant   <= 1'b0;
            load_grant    <= 1'b0;
            cpu_stall     <= 1'b0;
            rww_busy_flag <= 1'b0;
            irq_mask      <= 1'b0;
            lock_bits     <= 4'hf;
        end
        else
        begin
            store_grant   <= st_ok;
            load_grant    <= ld_ok & ~gen_unused | ld_ok;
            cpu_stall     <= (state_d == SPFG_NO_READ_WHILE_WRITE_REGION_BUSY);
            rww_busy_flag <= busy_d;
            irq_mask      <= (ivec_in_boot & app_rl & ~exe_boot) |
                             (~ivec_in_boot & boot_rl & exe_boot);
            lock_bits     <= lock_q;
        end
    end
endmodule

// ==== rtl/spfg_pkg.sv ====
// types for the self-program flash guard
`include "spfg_cfg.svh"
package spfg_pkg;
    typedef logic [`SPFG_ADDR_W-1:0] spfg_addr_t;
    typedef struct packed {
        logic       store;
        logic       load;
        logic       page_op;
        logic       page_load;
        logic       reenable;
        logic       lock_set;
        logic [3:0] lock_data;
        spfg_addr_t target;
        spfg_addr_t exec;
    } spfg_req_t;
    typedef enum logic [1:0] {SPFG_IDLE, SPFG_RWW_BUSY, SPFG_NO_READ_WHILE_WRITE_REGION_BUSY}
        spfg_state_t;
endpackage

// ==== verification/spfg_flash_model.sv ====
// flash array model that ends a page operation after a fixed delay
`timescale 1ns/10ps
module spfg_flash_model #(
    parameter int LAT = 6
)(
    input wire logic clk,
    input wire logic start,
    output logic     op_done
);
    int n = 0;
    initial op_done = 1'b0;
    // short delay stands in for the real erase or write time
    always @(posedge clk)
    begin
        op_done <= (n == 1);
        n <= start ? LAT : (n > 0 ? n - 1 : 0);
    end
endmodule

// ==== verification/spfg_guard_assertions.sv ====
// concurrent checks on the flash guard ports
`timescale 1ns/10ps
module spfg_guard_chk
    import spfg_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire spfg_req_t  req,
    input wire logic       op_done,
    input wire logic       chip_erase,
    input wire logic       store_grant,
    input wire logic       load_grant,
    input wire logic       cpu_stall,
    input wire logic       rww_busy_flag,
    input wire logic [3:0] lock_bits
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // granted page operation, hi selects the no-read-while-write region
    sequence s_op(hi);
        store_grant && $past(req.page_op && ((req.target >= 13'h1c00) == hi));
    endsequence
    a_app_store: assert property (req.store && req.exec < 13'h1c00
        |=> !store_grant) else $error("store from app part granted");
    a_rww_busy: assert property (s_op(0) |-> rww_busy_flag)
        else $error("busy not set");
    a_no_read_while_write_region_stall: assert property (s_op(1) |-> cpu_stall)
        else $error("cpu not stalled");
    a_stall_end: assert property ($fell(cpu_stall)
        |-> $past(op_done) || $past(op_done, 2)) else $error("stall ended");
    a_busy_load: assert property (rww_busy_flag && req.load
        && req.target < 13'h1c00 |=> !load_grant) else $error("rww read");
    a_no_read_while_write_region_read: assert property (rww_busy_flag && !cpu_stall &&
        req.load && req.target >= 13'h1c00 && lock_bits == 4'hf
        |=> load_grant) else $error("no_read_while_write_region read refused");
    // lock_bits trails the lock store by one cycle, so look two edges on
    a_erase_lock: assert property (chip_erase |=> ##1 lock_bits == 4'hf)
        else $error("locks not cleared");
    a_app_wlock: assert property (req.store && !lock_bits[0]
        && req.target < 13'h1c00 |=> !store_grant) else $error("app write");
endmodule
bind spfg_guard spfg_guard_chk i_chk (.clk, .rstn, .req, .op_done,
    .chip_erase, .store_grant, .load_grant, .cpu_stall, .rww_busy_flag,
    .lock_bits);

// ==== verification/tb_top.sv ====
// self-checking bench for the flash guard
`timescale 1ns/10ps
module tb_top
    import spfg_pkg::*;
;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t %h %h", $time, a, b); end end
    logic clk = 0, rstn = 0, chip_erase = 0, pg = 0, op_done;
    logic store_grant, load_grant, cpu_stall, rww_busy_flag, irq_mask;
    logic ivec = 1;
    logic [3:0] lock_bits;
    logic [1:0] g;
    spfg_req_t req = '0;
    int errors = 0, n_checks = 0, i;
    // store/load, target, exec, expected grants
    logic [37:0] rows [4] = '{{6'h20, 4'h0, 13'h0100, 13'h0010, 2'b00},
        {6'h20, 4'h0, 13'h1f90, 13'h1f90, 2'b10},
        {6'h10, 4'h0, 13'h1f90, 13'h0010, 2'b01},
        {6'h10, 4'h0, 13'h0100, 13'h1f90, 2'b01}};
    always #4 clk = ~clk;
    spfg_guard i_dut (.clk, .rstn, .req, .op_done, .boot_size_fuses(2'h3),
        .chip_erase, .ivec_in_boot(ivec), .gen_lock_w(1'b1),
        .gen_lock_rw(1'b1), .store_grant, .load_grant, .cpu_stall,
        .rww_busy_flag, .irq_mask, .lock_bits);
    spfg_flash_model i_fm (.clk, .start(store_grant & pg), .op_done);
    // one request, grants sampled just after the taking edge
    task automatic go(input logic [35:0] r);
        @(posedge clk) #1 req = r;
        @(posedge clk) #1 g = {store_grant, load_grant};
        req.store = 0;
        req.load = 0;
    endtask
    task automatic wt;
        for (i = 0; i < 40 && op_done !== 1'b1; i++) @(posedge clk) #1;
        if (op_done !== 1'b1)
        begin
            errors++;
            finish_test;
        end
        else
        begin
            repeat (3) @(posedge clk);
            #1;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rstn = 1;
        chip_erase = 1;
        @(posedge clk) #1 chip_erase = 0;
        @(posedge clk) #1;
        `CHK(lock_bits, 4'hf)
        foreach (rows[k])
        begin
            go(rows[k][37:2]);
            `CHK(g, rows[k][1:0])
        end
        pg = 1;
        go({6'h28, 4'h0, 13'h0100, 13'h1f90});
        `CHK({g, rww_busy_flag, cpu_stall}, 4'b1010)
        go({6'h10, 4'h0, 13'h0100, 13'h1f90});
        pg = 0;
        `CHK(g, 2'b00)
        go({6'h10, 4'h0, 13'h1d00, 13'h1f90});
        `CHK(g, 2'b01)
        wt;
        go({6'h22, 4'h0, 13'h0000, 13'h1f90});
        `CHK(rww_busy_flag, 1'b0)
        pg = 1;
        go({6'h28, 4'h0, 13'h1d00, 13'h1f90});
        `CHK({g, cpu_stall}, 3'b101)
        go({6'h10, 4'h0, 13'h1d00, 13'h1f90});
        pg = 0;
        `CHK(g, 2'b00)
        wt;
        `CHK(cpu_stall, 1'b0)
        pg = 1;
        go({6'h28, 4'h0, 13'h0100, 13'h1f90});
        wt;
        pg = 0;
        `CHK(rww_busy_flag, 1'b1)
        go({6'h24, 4'h0, 13'h0000, 13'h1f90});
        `CHK(rww_busy_flag, 1'b0)
        go({6'h21, 4'h0, 13'h0000, 13'h1f90});
        #8;
        `CHK(lock_bits, 4'h0)
        go({6'h20, 4'h0, 13'h0100, 13'h1f90});
        `CHK(g, 2'b00)
        go({6'h20, 4'h0, 13'h1f90, 13'h1f90});
        `CHK(g, 2'b00)
        go({6'h10, 4'h0, 13'h1f90, 13'h0010});
        `CHK(g, 2'b00)
        `CHK(irq_mask, 1'b1)
        go({6'h10, 4'h0, 13'h0100, 13'h1f90});
        `CHK(g, 2'b00)
        `CHK(irq_mask, 1'b0)
        ivec = 0;
        go({6'h00, 4'h0, 13'h0100, 13'h1f90});
        `CHK(irq_mask, 1'b1)
        chip_erase = 1;
        @(posedge clk) #1 chip_erase = 0;
        @(posedge clk) #1;
        `CHK(lock_bits, 4'hf)
        finish_test;
    end
endmodule
